// >>> rtl/swmon_regs.sv
// serial-reached slice of the switch monitor: polling current select, low-power entry, analog mux control
// assumes mode-0 serial framing sampled by a 40 MHz system clock; event inputs come from same-clock logic
//
// Notes on behaviour
// - a cleared polling select bit keeps that ground channel on default 1.0 mA polling.
// - a set polling select bit polls that ground channel with its wetting current.
// - polling select register at 0x17, read/write, bits 13..0, upper bits zero, resets zero.
// - low-power state is entered only by the dedicated low-power command.
// - entering or leaving low-power state never alters configuration registers.
// - write to 0x1C with all data zero enters low-power state and starts polling.
// - first frame after wake returns fault and interrupt flags high plus data chosen by the previous frame's address.
// - channel code 0 selects nothing, 1..14 ground inputs, 15..22 programmable inputs.
// - the routed input reads as 0 in switch status response words.
// - in normal state a new channel selection is applied on the write.
// - after reset no input is routed to the analog output.
// - source current bit 0 gives high impedance, 1 applies wetting current.
// - analog control at 0x1D, bit 6 current select, bits 5..0 channel, resets zero.
// - a frame starts at chip select falling and spans 32 serial clocks.
// - the interrupt flag clears once a response carrying it is returned.
// - responses carry fault flag in bit 23 and interrupt flag in bit 22.
`timescale 1ns/100ps
module swmon_regs
  import swmon_pkg::*;
(
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_N_I,
  input  wire logic              CS_N_I,
  input  wire logic              SCLK_I,
  input  wire logic              MOSI_I,
  input  wire logic [SW_CH-1:0]  SWITCH_I,
  input  wire logic              SWITCH_EVENT_I,
  input  wire logic              FAULT_EVENT_I,
  input  wire logic              FAULT_CLR_I,
  input  wire logic              WAKE_I,
  output logic                   MISO_O,
  output logic                   MISO_OE_N_O,
  output logic                   LOW_POWER_O,
  output logic [GND_CH-1:0]      POLL_WET_SEL_O,
  output logic                   ANALOG_MULTIPLEXER_OUTPUT_WET_O,
  output logic [SW_CH-1:0]       ANALOG_MULTIPLEXER_OUTPUT_ROUTE_O
);
  localparam int SYNC_W = SW_CH + 3;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: chip select, serial clock, data in, switch levels
  // select lane carries the inverted pin so its reset level equals idle: no false edge after reset
  logic [SYNC_W-1:0] s_lvl;
  logic [SYNC_W-1:0] s_rise;
  logic [SYNC_W-1:0] s_fall;

  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .pin_i     ({SWITCH_I, MOSI_I, SCLK_I, ~CS_N_I}),
    .lvl_o     (s_lvl),
    .rise_o    (s_rise),
    .fall_o    (s_fall)
  );

  logic             cs_fall;
  logic             cs_rise;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             mosi;
  logic [SW_CH-1:0] sw_lvl;

  assign cs_fall   = s_rise[0];
  assign cs_rise   = s_fall[0];
  assign sclk_rise = s_rise[1];
  assign sclk_fall = s_fall[1];
  assign mosi      = s_lvl[2];
  assign sw_lvl    = s_lvl[SYNC_W-1:3];

  ////////////////////////////////////////////////////////////////////////////
  // state
  spi_state_e               state_q, state_d;
  logic [CNT_W-1:0]         cnt_q, cnt_d;
  logic [FRAME_BITS-1:0]    rx_q, rx_d;
  logic [FRAME_BITS-1:0]    tx_q, tx_d;
  logic [6:0]               last_addr_q, last_addr_d;
  logic                     low_power_q, low_power_d;
  logic                     fault_q, fault_d;
  logic                     intflg_q, intflg_d;
  logic [GND_CH-1:0]        poll_q, poll_d;
  logic [ANALOG_MULTIPLEXER_OUTPUT_W-1:0]        analog_multiplexer_output_q, analog_multiplexer_output_d;
  logic [SW_CH-1:0]         route_q, route_d;
  logic                     oe_n_q, oe_n_d;

  logic                     exec;
  logic [6:0]               f_addr;
  logic                     f_wr;
  logic [DATA_W-1:0]        f_data;
  logic                     lp_cmd;
  logic [SW_CH-1:0]         sel_hit;
  logic [INT_BIT-1:0]       resp_data;

  assign f_addr = rx_q[FRAME_BITS-1:ADDR_LSB];
  assign f_wr   = (rx_q[DIR_BIT] == DIR_WRITE);
  assign f_data = rx_q[DATA_W-1:0];
  // only a complete 32-clock frame is executed
  assign exec   = cs_rise && (state_q == ST_SHIFT) && (cnt_q == CNT_W'(FRAME_BITS));
  assign lp_cmd = exec && f_wr && (f_addr == ADDR_ENTER_LP) && (f_data == LP_CMD_DATA);

  // one decoder lane per input; codes 1..22 map to status bit code-1
  genvar g;
  generate
    for (g = 0; g < SW_CH; g++) begin : g_route
      assign sel_hit[g] = (analog_multiplexer_output_d[ANALOG_MULTIPLEXER_OUTPUT_SEL_W-1:0] == ANALOG_MULTIPLEXER_OUTPUT_SEL_W'(g + 1));
    end
  endgenerate

  // response data for the frame about to start, chosen by the previous frame's address
  always_comb begin
    unique case (last_addr_q)
      ADDR_POLL_CUR:  resp_data = INT_BIT'(poll_q);
      ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL: resp_data = INT_BIT'(analog_multiplexer_output_q);
      default:        resp_data = sw_lvl & ~route_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    rx_d        = rx_q;
    tx_d        = tx_q;
    last_addr_d = last_addr_q;
    low_power_d = low_power_q;
    fault_d     = fault_q;
    intflg_d    = intflg_q;
    poll_d      = poll_q;
    analog_multiplexer_output_d      = analog_multiplexer_output_q;

    if (cs_fall) begin
      // flags in bits 23 and 22
      tx_d    = {RESP_TOP, fault_q, intflg_q, resp_data};
      state_d = ST_SHIFT;
      cnt_d   = '0;
      intflg_d = 1'b0;
    end else if (state_q == ST_SHIFT) begin
      if (cs_rise) begin
        state_d = ST_IDLE;
      end else begin
        if (sclk_rise && cnt_q != CNT_W'(FRAME_BITS)) begin
          rx_d  = {rx_q[FRAME_BITS-2:0], mosi};
          cnt_d = cnt_q + CNT_W'(1);
        end
        if (sclk_fall) begin
          tx_d = {tx_q[FRAME_BITS-2:0], 1'b0};
        end
      end
    end

    if (exec) begin
      last_addr_d = f_addr;
      if (f_wr && f_addr == ADDR_POLL_CUR) begin
        poll_d = f_data[GND_CH-1:0];
      end
      // analog control applied on the write in normal state
      if (f_wr && f_addr == ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL && !low_power_q) begin
        analog_multiplexer_output_d = f_data[ANALOG_MULTIPLEXER_OUTPUT_W-1:0];
      end
    end

    // only the command enters low power; registers untouched here
    if (lp_cmd) begin
      low_power_d = 1'b1;
    end
    if (FAULT_CLR_I) begin
      fault_d = 1'b0;
    end
    if (FAULT_EVENT_I) begin
      fault_d = 1'b1;
    end
    // event set wins over the read clear
    if (SWITCH_EVENT_I || FAULT_EVENT_I) begin
      intflg_d = 1'b1;
    end
    // wake raises both flags for the first frame
    if (WAKE_I) begin
      low_power_d = 1'b0;
      fault_d     = 1'b1;
      intflg_d    = 1'b1;
    end

    route_d = sel_hit;
    oe_n_d  = (state_d != ST_SHIFT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q     <= ST_IDLE;
      cnt_q       <= '0;
      rx_q        <= '0;
      tx_q        <= '0;
      last_addr_q <= ADDR_STATUS;
      low_power_q <= 1'b0;
      fault_q     <= FLAG_RESET;
      intflg_q    <= FLAG_RESET;
      poll_q      <= POLL_RESET;
      analog_multiplexer_output_q      <= ANALOG_MULTIPLEXER_OUTPUT_RESET;
      route_q     <= '0;
      oe_n_q      <= 1'b1;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      rx_q        <= rx_d;
      tx_q        <= tx_d;
      last_addr_q <= last_addr_d;
      low_power_q <= low_power_d;
      fault_q     <= fault_d;
      intflg_q    <= intflg_d;
      poll_q      <= poll_d;
      analog_multiplexer_output_q      <= analog_multiplexer_output_d;
      route_q     <= route_d;
      oe_n_q      <= oe_n_d;
    end
  end

  assign MISO_O         = tx_q[FRAME_BITS-1];
  assign MISO_OE_N_O    = oe_n_q;
  assign LOW_POWER_O    = low_power_q;
  // per-channel polling current: 0 default 1.0 mA, 1 wetting current
  assign POLL_WET_SEL_O = poll_q;
  assign ANALOG_MULTIPLEXER_OUTPUT_WET_O     = analog_multiplexer_output_q[ANALOG_MULTIPLEXER_OUTPUT_CUR_BIT];
  assign ANALOG_MULTIPLEXER_OUTPUT_ROUTE_O   = route_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  a_intflg_returned: assert property (
    cs_fall && !SWITCH_EVENT_I && !FAULT_EVENT_I && !WAKE_I |=> !intflg_q)
    else $error("interrupt flag not cleared after being returned");
  a_flags_in_word: assert property (
    cs_fall |=> tx_q[FAULT_BIT] == $past(fault_q) && tx_q[INT_BIT] == $past(intflg_q))
    else $error("response flags misplaced");
  a_lp_entry_cmd: assert property (
    lp_cmd && !WAKE_I |=> low_power_q)
    else $error("low-power command did not enter low power");
  a_lp_only_cmd: assert property (
    !low_power_q && !lp_cmd |=> !low_power_q)
    else $error("low power entered without the command");
  a_wake_flags: assert property (
    WAKE_I |=> fault_q && intflg_q && !low_power_q)
    else $error("wake did not raise both flags");
  a_cfg_kept_lp: assert property (
    $changed(low_power_q) |-> $stable(poll_q) && $stable(analog_multiplexer_output_q))
    else $error("configuration changed with power state");
  a_analog_multiplexer_output_write: assert property (
    exec && f_wr && f_addr == ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL && !low_power_q |=> analog_multiplexer_output_q == $past(rx_q[ANALOG_MULTIPLEXER_OUTPUT_W-1:0]))
    else $error("analog control write not applied");
  a_poll_write: assert property (
    exec && f_wr && f_addr == ADDR_POLL_CUR |=> poll_q == $past(rx_q[GND_CH-1:0]))
    else $error("polling select write not applied");
  a_route_none: assert property (
    analog_multiplexer_output_q[ANALOG_MULTIPLEXER_OUTPUT_SEL_W-1:0] == '0 || analog_multiplexer_output_q[ANALOG_MULTIPLEXER_OUTPUT_SEL_W-1:0] > ANALOG_MULTIPLEXER_OUTPUT_SEL_W'(SW_CH) |-> route_q == '0)
    else $error("input routed for an empty code");
  a_status_masked: assert property (
    cs_fall && route_q != '0 && last_addr_q != ADDR_POLL_CUR && last_addr_q != ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL
      |=> (tx_q[SW_CH-1:0] & $past(route_q)) == '0)
    else $error("routed input not reported as zero");
endmodule

// >>> rtl/swmon_pkg.sv
// constants for the switch monitor register slice: frame layout, addresses, reset values
// assumes a 32-bit serial frame, address first, most significant bit first
package swmon_pkg;
  localparam int          FRAME_BITS     = 32;
  localparam int          CNT_W          = 6;
  localparam int          ADDR_LSB       = 25;
  localparam int          DIR_BIT        = 24;
  localparam int          FAULT_BIT      = 23;
  localparam int          INT_BIT        = 22;
  localparam int          DATA_W         = 24;
  localparam int          GND_CH         = 14;
  localparam int          PROG_CH        = 8;
  localparam int          SW_CH          = 22;
  localparam int          ANALOG_MULTIPLEXER_OUTPUT_SEL_W     = 6;
  localparam int          ANALOG_MULTIPLEXER_OUTPUT_CUR_BIT   = 6;
  localparam int          ANALOG_MULTIPLEXER_OUTPUT_W         = 7;
  localparam logic [6:0]  ADDR_POLL_CUR  = 7'h17;
  localparam logic [6:0]  ADDR_ENTER_LP  = 7'h1C;
  localparam logic [6:0]  ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL = 7'h1D;
  localparam logic [6:0]  ADDR_STATUS    = 7'h1F;
  localparam logic        DIR_WRITE      = 1'b1;
  localparam logic [23:0] LP_CMD_DATA    = 24'h000000;
  localparam logic [13:0] POLL_RESET     = 14'h0000;
  localparam logic [6:0]  ANALOG_MULTIPLEXER_OUTPUT_RESET     = 7'h00;
  localparam logic [7:0]  RESP_TOP       = 8'h00;
  localparam logic        FLAG_RESET     = 1'b1;
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } spi_state_e;
endpackage

// >>> rtl/pin_sync.sv
// three-stage synchroniser with agreement filter and edge pulses, one lane per bit
// assumes asynchronous pin inputs and a single system clock
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] lvl_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);
  // elaboration check: at least one lane
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs at least one lane");
  end

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_d;
  logic [WIDTH-1:0] rise_d;
  logic [WIDTH-1:0] fall_d;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      // a change counts once the second and third stages agree
      always_comb begin
        lvl_d[g]  = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_o[g];
        rise_d[g] = lvl_d[g] & ~lvl_o[g];
        fall_d[g] = ~lvl_d[g] & lvl_o[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_o  <= '0;
      rise_o <= '0;
      fall_o <= '0;
    end else begin
      s1_q   <= pin_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_o  <= lvl_d;
      rise_o <= rise_d;
      fall_o <= fall_d;
    end
  end
endmodule

// >>> test/spi_master_model.sv
// serial master model: drives select, serial clock and data, captures the response word
// assumes eight system clocks per serial period; serial clock idles low outside frames
`timescale 1ns/100ps
module spi_master_model (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // select fall, 32 clocks, address first
  task automatic xfer(input logic [31:0] frame, output logic [31:0] resp);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 31; i >= 0; i--) begin
      mosi_o <= frame[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      // sampled before the fall: the device moves its data only after it
      resp[i] = miso_i;
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // released data line must not keep the last bit
    mosi_o <= ~frame[0];
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// >>> test/tb_top.sv
// self-checking bench for the switch monitor register slice
// assumes the serial master model drives the link pins at 200 ns per serial clock
`timescale 1ns/100ps
module tb_top
  import swmon_pkg::*;
;
  logic              clk_sys;
  logic              reset_n;
  logic              cs_n;
  logic              sclk;
  logic              mosi;
  logic              miso;
  logic              miso_oe_n;
  logic              miso_line;
  logic              low_power;
  logic              analog_multiplexer_output_wet;
  logic              switch_event;
  logic              fault_event;
  logic              fault_clr;
  logic              wake;
  logic [SW_CH-1:0]  switch_lvl;
  logic [SW_CH-1:0]  analog_multiplexer_output_route;
  logic [SW_CH-1:0]  prev_data;
  logic [GND_CH-1:0] poll_sel;
  logic [31:0]       resp;
  logic [6:0]        v;
  int                c;
  int                num_errors;
  int                checks_done;

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  // released data line shows the inverse of the last driven bit
  assign miso_line = miso_oe_n ? ~miso : miso;

  spi_master_model u_spi_master_model (.clk_i(clk_sys), .miso_i(miso_line), .cs_n_o(cs_n), .sclk_o(sclk),
                                       .mosi_o(mosi));
  swmon_regs u_swmon_regs (.CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .CS_N_I(cs_n), .SCLK_I(sclk),
    .MOSI_I(mosi), .SWITCH_I(switch_lvl), .SWITCH_EVENT_I(switch_event), .FAULT_EVENT_I(fault_event),
    .FAULT_CLR_I(fault_clr), .WAKE_I(wake), .MISO_O(miso), .MISO_OE_N_O(miso_oe_n),
    .LOW_POWER_O(low_power), .POLL_WET_SEL_O(poll_sel), .ANALOG_MULTIPLEXER_OUTPUT_WET_O(analog_multiplexer_output_wet), .ANALOG_MULTIPLEXER_OUTPUT_ROUTE_O(analog_multiplexer_output_route));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [6:0] addr, input logic dir, input logic [23:0] data);
    u_spi_master_model.xfer({addr, dir, data}, resp);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    switch_event = 1'b0;
    fault_event = 1'b0;
    fault_clr = 1'b0;
    wake = 1'b0;
    switch_lvl = 22'h2C3A5F;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check({analog_multiplexer_output_wet, analog_multiplexer_output_route}, 32'h0); // nothing routed
    check({poll_sel, low_power, miso_oe_n}, 32'h1); // reset values
    xfer(ADDR_POLL_CUR, 1'b0, 24'h0);
    check(resp, {8'h00, 2'b11, switch_lvl}); // flags after reset
    xfer(ADDR_POLL_CUR, DIR_WRITE, 24'hFFFFFF);
    check(resp, {8'h00, 2'b10, 22'h0}); // flag cleared, zero readback
    check(poll_sel, 32'h3FFF); // select bits
    prev_data = 22'h003FFF;
    for (c = 0; c < 25; c++) begin
      v = (c == 24) ? 7'h3F : {c[0], c[5:0]};
      xfer(ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL, DIR_WRITE, {17'h1FFFF, v});
      check(resp, {8'h00, 2'b10, prev_data}); // readback
      check(analog_multiplexer_output_route, (v[5:0] >= 1 && v[5:0] <= 22) ? (32'h1 << (v[5:0] - 1)) : 32'h0); // decode
      check(analog_multiplexer_output_wet, v[6]); // source current
      check(miso_oe_n, 1'b1); // released between frames
      prev_data = {15'h0, v};
    end
    xfer(ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL, DIR_WRITE, 24'h000043);
    check(analog_multiplexer_output_route, 32'h4); // applied on write
    xfer(ADDR_STATUS, 1'b0, 24'h0);
    check(resp, {8'h00, 2'b10, 22'h000043}); // readback
    xfer(ADDR_STATUS, 1'b0, 24'h0);
    check(resp, {8'h00, 2'b10, switch_lvl & ~22'h4}); // routed bit low
    // only the exact command enters low power
    xfer(ADDR_ENTER_LP, DIR_WRITE, 24'h000001);
    check(low_power, 1'b0); // nonzero data
    xfer(ADDR_ENTER_LP, 1'b0, LP_CMD_DATA);
    check(low_power, 1'b0); // read direction
    xfer(ADDR_ENTER_LP, DIR_WRITE, LP_CMD_DATA);
    check(low_power, 1'b1); // entered
    xfer(ADDR_ANALOG_MULTIPLEXER_OUTPUT_CTRL, DIR_WRITE, 24'h000005);
    check({analog_multiplexer_output_wet, analog_multiplexer_output_route}, {9'h0, 1'b1, 22'h4}); // dropped in low power
    @(posedge clk_sys);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(low_power, 1'b0); // woken
    check(poll_sel, 32'h3FFF); // kept
    check(analog_multiplexer_output_route, 32'h4); // kept
    xfer(ADDR_STATUS, 1'b0, 24'h0);
    check(resp[31:22], 10'h003); // both flags after wake
    xfer(ADDR_STATUS, 1'b0, 24'h0);
    check(resp, {8'h00, 2'b10, switch_lvl & ~22'h4}); // live status
    @(posedge clk_sys);
    fault_clr <= 1'b1;
    @(posedge clk_sys);
    fault_clr <= 1'b0;
    switch_event <= 1'b1;
    @(posedge clk_sys);
    switch_event <= 1'b0;
    xfer(ADDR_STATUS, 1'b0, 24'h0);
    check(resp, {8'h00, 2'b01, switch_lvl & ~22'h4}); // event flag only
    fault_event <= 1'b1;
    @(posedge clk_sys);
    fault_event <= 1'b0;
    xfer(ADDR_STATUS, 1'b0, 24'h0);
    check(resp[31:22], 10'h003); // fault sets both
    xfer(ADDR_STATUS, 1'b0, 24'h0);
    check(resp[31:22], 10'h002); // cleared once returned
    summarize();
  end
endmodule
